// file: test_message_responder_map.svh
// Constants of the test message responder: message identifiers and the short message field layout.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TEST_MESSAGE_RESPONDER_MAP_SVH
`define TEST_MESSAGE_RESPONDER_MAP_SVH

// Identifiers sent by the test equipment.
`define ID_VOL_UP        8'h33
`define ID_VOL_DOWN      8'h34
`define ID_STATUS_REQ    8'h35
`define ID_IND_REQ       8'h36
`define ID_PWR_REQ       8'h37
`define ID_BELL_REQ      8'h38
`define ID_MSG_REQ       8'h39
`define ID_KEYS          8'h3A
`define ID_HOOK_ON       8'h40
`define ID_HOOK_OFF      8'h41
`define ID_BEARER        8'h46
`define ID_SET_PWR       8'h50
`define ID_RESET_CMD     8'hFF

// Identifiers sent by the mobile unit.
`define ID_IND_RSP       8'h5C
`define ID_PWR_RSP       8'h5D
`define ID_MSG_RSP       8'h65
`define ID_NO_MSG_RSP    8'h66
`define ID_MALF_ERR      8'hF0
`define ID_NREC_ERR      8'hF1
`define ID_NPERF_ERR     8'hF2

// Arbitrary error indicator carried with the malfunction message.
`define MALF_INDICATOR   8'h01

// Short message field layout, byte offsets and sizes inside the field.
`define FLD_OA_OFS       8'h01
`define FLD_SC_OFS       8'h0D
`define FLD_UDL_OFS      8'h22
`define FLD_UD_OFS       8'h23
`define FLD_ADDR_BYTES   8'h0C
`define FLD_UD_MAX       8'h8C
`define FLD_BYTES        8'hAF

// Message lengths in octets.
`define LEN_SHORT        8'h01
`define LEN_PAIR         8'h02

`endif

// file: test_message_responder_pkg.sv
// Types of the test message responder.
// Assumes the constants header sits in the same folder.
`default_nettype none
`include "test_message_responder_map.svh"

package test_message_responder_pkg;

  typedef enum logic [2:0] {
    K_NONE  = 3'b000,
    K_IND   = 3'b001,
    K_PWR   = 3'b010,
    K_MSG   = 3'b011,
    K_NOSM  = 3'b100,
    K_MALF  = 3'b101,
    K_NREC  = 3'b110,
    K_NPERF = 3'b111
  } msg_kind_t;

  typedef enum logic {
    S_IDLE = 1'b0,
    S_SEND = 1'b1
  } resp_state_t;

endpackage
`default_nettype wire

// file: sm_field_store.sv
// Storage of the received short message field, read back octet by octet.
// Assumes the device writes the field through the write port before software asks for it.
`timescale 1ns/100ps
`default_nettype none
`include "test_message_responder_map.svh"

module msg_field_store (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [3:0] oa_len,
  input  wire logic [3:0] sc_len,
  // Read side
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic      [7:0] field_len
);

  logic [7:0] mem [0:174];
  logic [7:0] raw;
  logic [7:0] udl;
  logic       pad;

  always_ff @(posedge ref_clk) begin
    if (wr_en && wr_addr < `FLD_BYTES) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_comb begin
    raw = (rd_addr < `FLD_BYTES) ? mem[rd_addr] : 8'h00;
    udl = mem[`FLD_UDL_OFS];
    if (udl > `FLD_UD_MAX) begin
      udl = `FLD_UD_MAX;
    end
    // Address bytes past the stated length go out as null, whatever the writer left there.
    pad = ((rd_addr >= `FLD_OA_OFS) && (rd_addr < `FLD_SC_OFS) && ((rd_addr - `FLD_OA_OFS) >= {4'h0, oa_len}))
       || ((rd_addr >= `FLD_SC_OFS) && (rd_addr < `FLD_SC_OFS + `FLD_ADDR_BYTES)
           && ((rd_addr - `FLD_SC_OFS) >= {4'h0, sc_len}));
    rd_data   = (pad || rd_addr == 8'h00) ? 8'h00 : raw;
    field_len = `FLD_UD_OFS + udl;
  end

  property p_oa_pad;
    @(posedge ref_clk) disable iff (rst)
      (rd_addr >= `FLD_OA_OFS && rd_addr < `FLD_SC_OFS && (rd_addr - `FLD_OA_OFS) >= {4'h0, oa_len})
      |-> rd_data == 8'h00;
  endproperty
  a_oa_pad: assert property (p_oa_pad) else $error("Originating address padding is not null.");

endmodule
`default_nettype wire

// file: test_message_responder.sv
// Mobile unit side of the test message exchange: decodes request identifiers and sends replies.
// Assumes octets arrive and leave through a link layer that frames messages and waits for replies.
// How it works
// - Indication request answers 092 then a byte with service bit in bit 0.
// - Power request answers 093 then the current transmit power level byte.
// - Short message request with a stored message answers 101 plus field octets.
// - Field order: null, 12 address, 12 centre, pid, dcs, 7 stamp, length, data.
// - Address bytes beyond the address length are sent as null.
// - Short message request without stored message answers single octet 102.
// - Internal faults are reported only as a reply to a received message.
// - Correct but not understandable messages are ignored and answered with 241.
// - Receiving 241 makes the unit resend a reply of the kind it last transmitted, rebuilt from current inputs; 242 if none since reset.
// - Understood but unsupported requests are answered with the not performable error.
// - Identifier 255 causes a total reset equal to a power cycle.
// - Indication, power and short message requests get their matching response unless a fault is pending, which gives 240.
// - The not performable error carries identifier 242.
// - Identifiers 240 to 254 are for errors; undefined values are never sent.
`timescale 1ns/100ps
`default_nettype none
`include "test_message_responder_map.svh"

module test_message_responder
  import test_message_responder_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Received octets, first octet of a message flagged
  input  wire logic       rx_valid,
  input  wire logic       rx_first,
  input  wire logic [7:0] rx_octet,
  // Transmitted octets
  output logic            tx_valid,
  output logic      [7:0] tx_octet,
  output logic            tx_last,
  input  wire logic       tx_ready,
  // Device state reported in replies
  input  wire logic       service_on,
  input  wire logic [7:0] power_level,
  input  wire logic       msg_stored,
  input  wire logic       internal_fault,
  // Short message field write port
  input  wire logic       fld_wr_en,
  input  wire logic [7:0] fld_wr_addr,
  input  wire logic [7:0] fld_wr_data,
  input  wire logic [3:0] oa_len,
  input  wire logic [3:0] sc_len,
  // Total reset request to the rest of the unit
  output logic            total_reset
);

  import test_message_responder_pkg::*;

  resp_state_t state;
  resp_state_t next_state;
  msg_kind_t   kind;
  msg_kind_t   next_kind;
  msg_kind_t   last_kind;
  msg_kind_t   next_last_kind;
  msg_kind_t   req_kind;
  logic [7:0]  idx;
  logic [7:0]  next_idx;
  logic [7:0]  len;
  logic [7:0]  octet;
  logic [7:0]  fld_rd_data;
  logic [7:0]  fld_len;
  logic        fault_seen;
  logic        next_fault_seen;
  logic        next_tx_valid;
  logic [7:0]  next_tx_octet;
  logic        next_tx_last;
  logic        next_total_reset;
  logic        take;
  logic        load;

  msg_field_store u_store (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .wr_en     (fld_wr_en),
    .wr_addr   (fld_wr_addr),
    .wr_data   (fld_wr_data),
    .oa_len    (oa_len),
    .sc_len    (sc_len),
    .rd_addr   (idx - 8'h01),
    .rd_data   (fld_rd_data),
    .field_len (fld_len)
  );

  // New requests are only taken once the previous reply has fully left.
  assign take = (state == S_IDLE) && !tx_valid && rx_valid && rx_first;
  assign load = (state == S_SEND) && (!tx_valid || tx_ready);

  // Request decode with fault and resend priority.
  always_comb begin
    unique case (rx_octet)
      `ID_IND_REQ:    req_kind = K_IND;
      `ID_PWR_REQ:    req_kind = K_PWR;
      `ID_MSG_REQ:    req_kind = msg_stored ? K_MSG : K_NOSM;
      `ID_VOL_UP, `ID_VOL_DOWN, `ID_STATUS_REQ, `ID_BELL_REQ, `ID_KEYS,
      `ID_HOOK_ON, `ID_HOOK_OFF, `ID_BEARER, `ID_SET_PWR:
                      req_kind = K_NPERF;
      `ID_NREC_ERR:   req_kind = (last_kind == K_NONE) ? K_NPERF : last_kind;
      default:        req_kind = K_NREC;
    endcase
    if (fault_seen) begin
      req_kind = K_MALF;
    end
  end

  // Length and octet of the reply under way.
  always_comb begin
    unique case (kind)
      K_IND, K_PWR, K_MALF: len = `LEN_PAIR;
      K_MSG:                len = `LEN_SHORT + fld_len;
      default:              len = `LEN_SHORT;
    endcase
    octet = 8'h00;
    if (idx == 8'h00) begin
      unique case (kind)
        K_IND:   octet = `ID_IND_RSP;
        K_PWR:   octet = `ID_PWR_RSP;
        K_MSG:   octet = `ID_MSG_RSP;
        K_NOSM:  octet = `ID_NO_MSG_RSP;
        K_MALF:  octet = `ID_MALF_ERR;
        K_NREC:  octet = `ID_NREC_ERR;
        default: octet = `ID_NPERF_ERR;
      endcase
    end else begin
      unique case (kind)
        K_IND:   octet = {7'h00, service_on};
        K_PWR:   octet = power_level;
        K_MSG:   octet = fld_rd_data;
        K_MALF:  octet = `MALF_INDICATOR;
        default: octet = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_state       = state;
    next_kind        = kind;
    next_last_kind   = last_kind;
    next_idx         = idx;
    next_tx_valid    = tx_valid;
    next_tx_octet    = tx_octet;
    next_tx_last     = tx_last;
    next_total_reset = 1'b0;
    // A fault arriving while the latch is being cleared stays recorded.
    next_fault_seen  = fault_seen || internal_fault;
    unique case (state)
      S_IDLE: begin
        if (tx_valid && tx_ready) begin
          next_tx_valid = 1'b0;
          next_tx_last  = 1'b0;
        end
        if (take) begin
          if (rx_octet == `ID_RESET_CMD) begin
            next_total_reset = 1'b1;
            next_last_kind   = K_NONE;
            next_fault_seen  = internal_fault;
          end else begin
            next_kind       = req_kind;
            next_idx        = 8'h00;
            next_state      = S_SEND;
            next_fault_seen = internal_fault;
          end
        end
      end
      S_SEND: begin
        if (load) begin
          next_tx_valid = 1'b1;
          next_tx_octet = octet;
          next_tx_last  = (idx == len - 8'h01);
          next_idx      = idx + 8'h01;
          if (idx == len - 8'h01) begin
            next_state     = S_IDLE;
            next_last_kind = kind;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state       <= S_IDLE;
      kind        <= K_NONE;
      last_kind   <= K_NONE;
      idx         <= 8'h00;
      fault_seen  <= 1'b0;
      tx_valid    <= 1'b0;
      tx_octet    <= 8'h00;
      tx_last     <= 1'b0;
      total_reset <= 1'b0;
    end else begin
      state       <= next_state;
      kind        <= next_kind;
      last_kind   <= next_last_kind;
      idx         <= next_idx;
      fault_seen  <= next_fault_seen;
      tx_valid    <= next_tx_valid;
      tx_octet    <= next_tx_octet;
      tx_last     <= next_tx_last;
      total_reset <= next_total_reset;
    end
  end

  sequence s_take(logic [7:0] id);
    take && rx_octet == id && !fault_seen;
  endsequence

  sequence s_first(logic [7:0] id);
    ##2 (tx_valid && tx_octet == id);
  endsequence

  property p_ind;
    @(posedge ref_clk) disable iff (rst) s_take(`ID_IND_REQ) |-> s_first(`ID_IND_RSP) ##0 !tx_last;
  endproperty
  a_ind: assert property (p_ind) else $error("Indication request not answered with 092.");

  property p_ind_body;
    @(posedge ref_clk) disable iff (rst)
      (tx_valid && tx_ready && kind == K_IND && tx_octet == `ID_IND_RSP && !tx_last)
      |-> ##[1:2] (tx_valid && tx_last && tx_octet[7:1] == 7'h00);
  endproperty
  a_ind_body: assert property (p_ind_body) else $error("Indication field malformed.");

  property p_pwr;
    @(posedge ref_clk) disable iff (rst) s_take(`ID_PWR_REQ) |-> s_first(`ID_PWR_RSP);
  endproperty
  a_pwr: assert property (p_pwr) else $error("Power request not answered with 093.");

  property p_msg;
    @(posedge ref_clk) disable iff (rst) (s_take(`ID_MSG_REQ) ##0 msg_stored) |-> s_first(`ID_MSG_RSP);
  endproperty
  a_msg: assert property (p_msg) else $error("Stored short message not answered with 101.");

  property p_nosm;
    @(posedge ref_clk) disable iff (rst)
      (s_take(`ID_MSG_REQ) ##0 !msg_stored) |-> s_first(`ID_NO_MSG_RSP) ##0 tx_last;
  endproperty
  a_nosm: assert property (p_nosm) else $error("Missing short message not answered with 102.");

  property p_malf;
    @(posedge ref_clk) disable iff (rst)
      (take && fault_seen && rx_octet != `ID_RESET_CMD) |-> ##2 (tx_valid && tx_octet == `ID_MALF_ERR);
  endproperty
  a_malf: assert property (p_malf) else $error("Pending fault not reported as 240.");

  property p_nrec;
    @(posedge ref_clk) disable iff (rst) s_take(8'h00) |-> s_first(`ID_NREC_ERR) ##0 tx_last;
  endproperty
  a_nrec: assert property (p_nrec) else $error("Unknown identifier not answered with 241.");

  property p_nperf;
    @(posedge ref_clk) disable iff (rst) s_take(`ID_KEYS) |-> s_first(`ID_NPERF_ERR);
  endproperty
  a_nperf: assert property (p_nperf) else $error("Unsupported request not answered with 242.");

  property p_resend;
    @(posedge ref_clk) disable iff (rst) (s_take(`ID_NREC_ERR) ##0 last_kind == K_PWR) |-> s_first(`ID_PWR_RSP);
  endproperty
  a_resend: assert property (p_resend) else $error("Resend did not repeat the power reply.");

  property p_reset;
    @(posedge ref_clk) disable iff (rst)
      (take && rx_octet == `ID_RESET_CMD) |=> total_reset ##1 (!total_reset && last_kind == K_NONE && state == S_IDLE);
  endproperty
  a_reset: assert property (p_reset) else $error("Reset command did not give a one-cycle total reset.");

endmodule
`default_nettype wire

// file: sim_equipment.sv
// Behavioural model of the test equipment: sends request identifiers and drains reply octets.
// Assumes it shares the responder's clock and is driven by testbench calls to its tasks.
`timescale 1ns/100ps
`default_nettype none

module sim_equipment (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Request side
  output logic            rx_valid,
  output logic            rx_first,
  output logic      [7:0] rx_octet,
  // Reply side
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_octet,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] rsp [0:199];
  logic [7:0] rsp_n;
  logic       timed_out;

  initial begin
    rx_valid  = 1'b0;
    rx_first  = 1'b0;
    rx_octet  = 8'h00;
    tx_ready  = 1'b1;
    rsp_n     = 8'h00;
    timed_out = 1'b0;
  end

  // The octet line shows the inverse once released, so a stale octet cannot pass for a request.
  task automatic send(input logic [7:0] id);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_first <= 1'b1;
    rx_octet <= id;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    rx_octet <= ~id;
  endtask

  // The whole reply is drained before the caller may send again.
  task automatic collect(input logic slow);
    logic done;
    done      = 1'b0;
    rsp_n     = 8'h00;
    timed_out = 1'b0;
    for (int i = 0; i < 800 && !done; i++) begin
      @(posedge ref_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1 && rst === 1'b0) begin
        rsp[rsp_n] = tx_octet;
        rsp_n      = rsp_n + 8'h01;
        done       = (tx_last === 1'b1);
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    timed_out = !done;
  endtask
endmodule
`default_nettype wire

// file: test_message_responder_tb.sv
// Self-checking testbench of the test message responder, one task per scenario.
// Assumes the package, the constants header and the equipment model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "test_message_responder_map.svh"

module test_message_responder_tb;
  logic       ref_clk, rst, rx_valid, rx_first, tx_valid, tx_last, tx_ready, total_reset;
  logic       service_on, msg_stored, internal_fault, fld_wr_en;
  logic [7:0] rx_octet, tx_octet, power_level, fld_wr_addr, fld_wr_data;
  logic [3:0] oa_len, sc_len;
  logic [7:0] exp_q [$];
  int         miscompares, n_compared;

  test_message_responder i_dut (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_octet(rx_octet), .tx_valid(tx_valid), .tx_octet(tx_octet), .tx_last(tx_last), .tx_ready(tx_ready),
    .service_on(service_on), .power_level(power_level), .msg_stored(msg_stored), .internal_fault(internal_fault),
    .fld_wr_en(fld_wr_en), .fld_wr_addr(fld_wr_addr), .fld_wr_data(fld_wr_data), .oa_len(oa_len),
    .sc_len(sc_len),
    .total_reset(total_reset));
  sim_equipment i_sim (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_octet(rx_octet), .tx_valid(tx_valid), .tx_octet(tx_octet), .tx_last(tx_last), .tx_ready(tx_ready));

  task automatic report_and_stop();
    $display("Compared %0d values, %0d mismatches", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
    n_compared++;
    if (seen !== expected) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, expected, seen);
    end
  endtask

  // Sends one identifier, drains the reply and compares it against exp_q.
  task automatic run(input logic [7:0] id, input logic slow);
    i_sim.send(id);
    i_sim.collect(slow);
    if (i_sim.timed_out === 1'b1) begin
      miscompares++;
      $display("MISMATCH reply to %h expected complete seen unfinished", id);
      report_and_stop();
    end else begin
      check("reply length", i_sim.rsp_n, 8'(exp_q.size()));
      for (int k = 0; k < exp_q.size() && k < i_sim.rsp_n; k++) begin
        check("reply octet", i_sim.rsp[k], exp_q[k]);
      end
    end
  endtask

  task automatic t_indication();
    for (int s = 0; s < 2; s++) begin
      service_on <= s[0];
      exp_q = {`ID_IND_RSP, 8'(s[0])};
      run(`ID_IND_REQ, 1'b0);
    end
    $display("Test indication done");
  endtask

  task automatic t_power();
    power_level <= 8'hA5;
    exp_q = {`ID_PWR_RSP, 8'hA5};
    run(`ID_PWR_REQ, 1'b1);
    power_level <= 8'h3C;
    exp_q = {`ID_PWR_RSP, 8'h3C};
    run(`ID_NREC_ERR, 1'b0);
    $display("Test power and resend done");
  endtask

  task automatic t_errors();
    logic [7:0] known [9] = '{`ID_VOL_UP, `ID_VOL_DOWN, `ID_STATUS_REQ, `ID_BELL_REQ, `ID_KEYS,
                              `ID_HOOK_ON, `ID_HOOK_OFF, `ID_BEARER, `ID_SET_PWR};
    logic [7:0] odd [5] = '{8'h00, 8'h5C, 8'hF0, 8'hF2, 8'hFE};
    foreach (known[k]) begin
      exp_q = {`ID_NPERF_ERR};
      run(known[k], 1'b0);
    end
    foreach (odd[k]) begin
      exp_q = {`ID_NREC_ERR};
      run(odd[k], 1'b0);
    end
    $display("Test error replies done");
  endtask

  // Every field byte carries a distinct value, so a swapped or shifted part shows up.
  task automatic t_short_msg();
    msg_stored <= 1'b0;
    exp_q = {`ID_NO_MSG_RSP};
    run(`ID_MSG_REQ, 1'b0);
    oa_len <= 4'h5;
    sc_len <= 4'hB;
    for (int a = 0; a < 38; a++) begin
      @(posedge ref_clk);
      fld_wr_en   <= 1'b1;
      fld_wr_addr <= 8'(a);
      fld_wr_data <= (a == 34) ? 8'h03 : 8'(a) ^ 8'hA0;
    end
    @(posedge ref_clk);
    fld_wr_en  <= 1'b0;
    msg_stored <= 1'b1;
    exp_q = {`ID_MSG_RSP};
    for (int a = 0; a < 38; a++) begin
      exp_q.push_back((a == 0 || (a > 5 && a < 13) || a == 24) ? 8'h00 : (a == 34) ? 8'h03 : 8'(a) ^ 8'hA0);
    end
    run(`ID_MSG_REQ, 1'b1);
    $display("Test short message done");
  endtask

  task automatic t_fault();
    int loud;
    loud = 0;
    @(posedge ref_clk);
    internal_fault <= 1'b1;
    @(posedge ref_clk);
    internal_fault <= 1'b0;
    repeat (20) begin
      @(posedge ref_clk);
      if (tx_valid !== 1'b0) loud++;
    end
    check("unsolicited octets", 8'(loud), 8'h00);
    exp_q = {`ID_MALF_ERR, `MALF_INDICATOR};
    run(`ID_IND_REQ, 1'b0);
    exp_q = {`ID_IND_RSP, 8'h01};
    run(`ID_IND_REQ, 1'b0);
    $display("Test malfunction done");
  endtask

  task automatic t_reset();
    int pulses;
    pulses = 0;
    i_sim.send(`ID_RESET_CMD);
    repeat (10) begin
      @(posedge ref_clk);
      if (total_reset === 1'b1) pulses++;
      if (tx_valid !== 1'b0) pulses += 16;
    end
    check("reset pulses", 8'(pulses), 8'h01);
    exp_q = {`ID_NPERF_ERR};
    run(`ID_NREC_ERR, 1'b0);
    $display("Test total reset done");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    miscompares    = 0;
    n_compared     = 0;
    rst            = 1'b1;
    service_on     = 1'b0;
    power_level    = 8'h00;
    msg_stored     = 1'b0;
    internal_fault = 1'b0;
    fld_wr_en      = 1'b0;
    fld_wr_addr    = 8'h00;
    fld_wr_data    = 8'h00;
    oa_len         = 4'h0;
    sc_len         = 4'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_indication();
    t_power();
    t_errors();
    t_short_msg();
    t_fault();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
